// *** shared/ptm_consts.svh ***
// Constants for the periodic timer: register offsets, field positions, reset values.
// Assumes inclusion by bare name from the design file and the bench.
`ifndef PTM_CONSTS_SVH
`define PTM_CONSTS_SVH
// Byte addresses on a 32-bit classic Wishbone bus, one word per register
`define PTM_OFS_CTRL0     8'h00
`define PTM_OFS_CTRL1     8'h04
`define PTM_OFS_CNT_LO    8'h08
`define PTM_OFS_CNT_HI    8'h0C
`define PTM_OFS_CMPA_LO   8'h10
`define PTM_OFS_CMPA_HI   8'h14
`define PTM_OFS_PER_LO    8'h18
`define PTM_OFS_PER_HI    8'h1C
`define PTM_OFS_STATUS    8'h20
// Control register 0 fields
`define PTM_C0_PAUSE      7
`define PTM_C0_CKSEL_HI   6
`define PTM_C0_CKSEL_LO   4
`define PTM_C0_RUN        3
// Control register 1 fields
`define PTM_C1_MODE_HI    7
`define PTM_C1_MODE_LO    6
`define PTM_C1_PINF_HI    5
`define PTM_C1_PINF_LO    4
`define PTM_C1_OC         3
`define PTM_C1_POL        2
`define PTM_C1_CCLR       0
// Reset values
`define PTM_RST_BYTE      8'h00
`define PTM_RST_VAL10     10'h000
// Prescaler limits for the internal clock taps, and the counter top value
`define PTM_DIV4_LAST     6'h03
`define PTM_DIV16_LAST    6'h0F
`define PTM_DIV64_LAST    6'h3F
`define PTM_CNT_MAX       10'h3FF
`endif

// *** shared/ptm_pkg.sv ***
// Types for the periodic timer.
// Assumes the constants header is on the include path.
package ptm_pkg;
	typedef enum logic [1:0] {
		PTM_MODE_CMP  = 2'h0,
		PTM_MODE_UNDF = 2'h1,
		PTM_MODE_PWM  = 2'h2,
		PTM_MODE_TMR  = 2'h3
	} ptm_mode_t;
	typedef enum logic [2:0] {
		PTM_CK_SYS4   = 3'h0,
		PTM_CK_SYS    = 3'h1,
		PTM_CK_H16    = 3'h2,
		PTM_CK_H64    = 3'h3,
		PTM_CK_SUB0   = 3'h4,
		PTM_CK_SUB1   = 3'h5,
		PTM_CK_EXTR   = 3'h6,
		PTM_CK_EXTF   = 3'h7
	} ptm_cksel_t;
	typedef enum logic [1:0] {
		PTM_BUS_IDLE  = 2'b01,
		PTM_BUS_ACK   = 2'b10
	} ptm_bus_t;
	typedef struct packed {
		logic [7:0]  ctrl0;
		logic [7:0]  ctrl1;
		logic [9:0]  cnt;
		logic [9:0]  cmpa;
		logic [9:0]  per;
		logic [1:0]  cmpa_hold;
		logic [1:0]  per_hold;
		logic [7:0]  cmpa_stage;
		logic [7:0]  per_stage;
		logic [5:0]  pre_sys;
		logic [5:0]  pre_h;
		logic        sub_d;
		logic        ext_d;
		logic        run_d;
		logic        out_lvl;
		logic        pin;
		logic        flag_a;
		logic        flag_p;
		logic        sticky_a;
		logic        sticky_p;
		ptm_bus_t    bus;
		logic        ack;
		logic [31:0] rdat;
	} ptm_state_t;
endpackage : ptm_pkg

// *** src/ptm_timer.sv ***
// Periodic timer: 10-bit up counter, two comparators, four modes, Wishbone slave.
// Assumes one clock, synchronous pins, a high clock enable and a sub clock level from the clock unit.
//
// Summary of operation
// - Ten-bit up counter steps on each tick of the chosen clock source.
// - Counter is compared continuously with compare A and ten-bit period value.
// - Software cannot load counter; run bit rising clears it to zero.
// - Overflow or selected match clears counter and raises a timer request.
// - Pause bit holds the counter value; counting resumes from it afterward.
// - Clock field picks sys/4, sys, high/16, high/64, sub, or pin edges.
// - Run bit one counts; zero stops and keeps the residual value.
// - Run bit rising sets output to the initial level in output modes.
// - Mode field: compare output, undefined, PWM or pulse, timer/counter.
// - Compare mode match: none, low, high, or toggle per pin field.
// - PWM modes pin field: inactive, active, PWM waveform, single pulse.
// - Match requesting the current level leaves output unchanged.
// - Output control bit gives initial, active, or pulse start level.
// - Timer/counter mode ignores output control and polarity; pin held low.
// - Polarity bit one inverts the output pin; zero passes it through.
// - Clear select outside PWM mode: one clears on A match; zero on period match or overflow.
// - Counter readable as low byte and two-bit high byte, upper bits zero.
// - Compare A and period each stored as low byte plus two-bit high.
// - PWM period from period value, zero meaning 1024; duty from compare A.
// - Single pulse: A match clears run bit; pin edge sets run bit.
// - Compare mode with clear select one raises only the compare A flag.
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "ptm_consts.svh"
module ptm_timer
	import ptm_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// Internal high clock tick enable and sub clock level from the clock unit
	input  wire logic        clk_high_tick_i,
	input  wire logic        clk_sub_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Pins and events
	input  wire logic        ext_clock_pin_i,
	output logic             timer_output_pin_o,
	output logic             compare_a_flag_o,
	output logic             period_match_flag_o
);
	ptm_state_t st;
	ptm_state_t next_st;

	// ------------------------------------------------------------
	// Derived control fields
	// ------------------------------------------------------------
	logic       pause_bit;
	logic       run_control_bit;
	ptm_cksel_t clock_select_field;
	ptm_mode_t  mode_field;
	logic [1:0] pin_function_field;
	logic       output_control_bit;
	logic       polarity_bit;
	logic       clear_select_bit;
	assign pause_bit          = st.ctrl0[`PTM_C0_PAUSE];
	assign run_control_bit    = st.ctrl0[`PTM_C0_RUN];
	assign clock_select_field = ptm_cksel_t'(st.ctrl0[`PTM_C0_CKSEL_HI:`PTM_C0_CKSEL_LO]);
	assign mode_field         = ptm_mode_t'(st.ctrl1[`PTM_C1_MODE_HI:`PTM_C1_MODE_LO]);
	assign pin_function_field = st.ctrl1[`PTM_C1_PINF_HI:`PTM_C1_PINF_LO];
	assign output_control_bit = st.ctrl1[`PTM_C1_OC];
	assign polarity_bit       = st.ctrl1[`PTM_C1_POL];
	assign clear_select_bit   = st.ctrl1[`PTM_C1_CCLR];

	// Wishbone request strobe and edges of the pins
	logic wb_req;
	logic ext_rise;
	logic ext_fall;
	logic sub_rise;
	assign wb_req   = wb_cyc_i & wb_stb_i & (st.bus == PTM_BUS_IDLE);
	assign ext_rise = ext_clock_pin_i & ~st.ext_d;
	assign ext_fall = ~ext_clock_pin_i & st.ext_d;
	assign sub_rise = clk_sub_i & ~st.sub_d;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	logic       tick;
	logic       counting;
	logic       match_a;
	logic       match_p;
	logic       ovf;
	logic [9:0] inc;
	logic       clr;
	logic       run_rise;
	logic       ext_edge;
	logic       pwm_on;
	logic [7:0] wbyte;
	logic [7:0] rbyte;
	always_comb begin
		next_st  = st;
		tick     = 1'b0;
		wbyte    = wb_dat_i[7:0];
		rbyte    = 8'h00;
		next_st.sub_d = clk_sub_i;
		next_st.ext_d = ext_clock_pin_i;
		next_st.run_d = run_control_bit;
		// Prescalers free-run so that switching source needs no restart
		next_st.pre_sys = (st.pre_sys == `PTM_DIV4_LAST) ? 6'h00 : st.pre_sys + 6'h01;
		if (clk_high_tick_i) begin
			next_st.pre_h = st.pre_h + 6'h01;
		end
		// Clock source select
		unique case (clock_select_field)
			PTM_CK_SYS4: tick = (st.pre_sys == `PTM_DIV4_LAST);
			PTM_CK_SYS:  tick = 1'b1;
			PTM_CK_H16:  tick = clk_high_tick_i & (st.pre_h[3:0] == `PTM_DIV16_LAST);
			PTM_CK_H64:  tick = clk_high_tick_i & (st.pre_h == `PTM_DIV64_LAST);
			PTM_CK_SUB0,
			PTM_CK_SUB1: tick = sub_rise;
			PTM_CK_EXTR: tick = ext_rise;
			PTM_CK_EXTF: tick = ext_fall;
		endcase
		ext_edge = (clock_select_field == PTM_CK_EXTF) ? ext_fall : ext_rise;
		run_rise = run_control_bit & ~st.run_d;
		// Comparators look at the value the count is about to reach, so a match shows as it arrives
		inc      = st.cnt + 10'h001;
		match_a  = (inc == st.cmpa);
		match_p  = (inc == st.per);
		ovf      = (st.cnt == `PTM_CNT_MAX);
		counting = run_control_bit & ~pause_bit & ~run_rise & tick;
		next_st.flag_a = 1'b0;
		next_st.flag_p = 1'b0;
		clr = 1'b0;
		if (run_rise) begin
			next_st.cnt = `PTM_RST_VAL10;
		end else if (counting) begin
			if (mode_field == PTM_MODE_PWM) begin
				clr = (st.per == `PTM_RST_VAL10) ? ovf : match_p;
				next_st.flag_a = match_a;
				next_st.flag_p = match_p;
			end else if (clear_select_bit) begin
				clr = match_a;
				next_st.flag_a = match_a & (st.cmpa != `PTM_RST_VAL10);
			end else begin
				clr = (st.per == `PTM_RST_VAL10) ? ovf : match_p;
				next_st.flag_a = match_a & (st.cmpa != `PTM_RST_VAL10);
				next_st.flag_p = match_p;
			end
			next_st.cnt = clr ? `PTM_RST_VAL10 : inc;
		end
		// Output level per mode
		if (run_rise) begin
			next_st.out_lvl = output_control_bit;
		end else if (counting && mode_field == PTM_MODE_CMP && match_a && st.cmpa != `PTM_RST_VAL10) begin
			unique case (pin_function_field)
				2'h0: next_st.out_lvl = st.out_lvl;
				2'h1: next_st.out_lvl = 1'b0;
				2'h2: next_st.out_lvl = 1'b1;
				2'h3: next_st.out_lvl = ~st.out_lvl;
			endcase
		end
		pwm_on = (st.cmpa >= st.per && st.per != `PTM_RST_VAL10) || (st.cnt < st.cmpa);
		unique case (mode_field)
			PTM_MODE_CMP:  next_st.pin = st.out_lvl ^ polarity_bit;
			PTM_MODE_PWM: begin
				unique case (pin_function_field)
					2'h0: next_st.pin = ~output_control_bit ^ polarity_bit;
					2'h1: next_st.pin = output_control_bit ^ polarity_bit;
					2'h2: next_st.pin = (pwm_on ? output_control_bit : ~output_control_bit) ^ polarity_bit;
					2'h3: next_st.pin = (run_control_bit ? output_control_bit : ~output_control_bit) ^ polarity_bit;
				endcase
			end
			PTM_MODE_UNDF,
			PTM_MODE_TMR:  next_st.pin = 1'b0;
		endcase
		// Register bus: one wait state, ack and read data for one cycle
		next_st.ack  = 1'b0;
		next_st.bus  = PTM_BUS_IDLE;
		next_st.rdat = 32'h0000_0000;
		if (wb_req) begin
			next_st.ack = 1'b1;
			next_st.bus = PTM_BUS_ACK;
			unique case (wb_adr_i)
				`PTM_OFS_CTRL0:   rbyte = {st.ctrl0[7:3], 3'b000};
				`PTM_OFS_CTRL1:   rbyte = st.ctrl1;
				`PTM_OFS_CNT_LO:  rbyte = st.cnt[7:0];
				`PTM_OFS_CNT_HI:  rbyte = {6'h00, st.cnt[9:8]};
				`PTM_OFS_CMPA_LO: rbyte = st.cmpa_hold[0] ? 8'h00 : st.cmpa[7:0];
				`PTM_OFS_CMPA_HI: rbyte = {6'h00, st.cmpa[9:8]};
				`PTM_OFS_PER_LO:  rbyte = st.per_hold[0] ? 8'h00 : st.per[7:0];
				`PTM_OFS_PER_HI:  rbyte = {6'h00, st.per[9:8]};
				`PTM_OFS_STATUS:  rbyte = {6'h00, st.sticky_p, st.sticky_a};
				default:          rbyte = 8'h00;
			endcase
			next_st.rdat = {24'h00_0000, rbyte};
			if (wb_we_i && wb_sel_i[0]) begin
				unique case (wb_adr_i)
					`PTM_OFS_CTRL0:   next_st.ctrl0 = {wbyte[7:3], 3'b000};
					`PTM_OFS_CTRL1:   next_st.ctrl1 = {wbyte[7:2], 1'b0, wbyte[0]};
					// Low bytes wait in their own staging copy; reads in between cannot disturb them
					`PTM_OFS_CMPA_LO: begin
						next_st.cmpa_stage = wbyte;
						next_st.cmpa_hold  = 2'b01;
					end
					`PTM_OFS_CMPA_HI: begin
						if (st.cmpa_hold[0]) begin
							next_st.cmpa      = {wbyte[1:0], st.cmpa_stage};
							next_st.cmpa_hold = 2'b00;
						end
					end
					`PTM_OFS_PER_LO: begin
						next_st.per_stage = wbyte;
						next_st.per_hold  = 2'b01;
					end
					`PTM_OFS_PER_HI: begin
						if (st.per_hold[0]) begin
							next_st.per      = {wbyte[1:0], st.per_stage};
							next_st.per_hold = 2'b00;
						end
					end
					// Sticky status: write one to clear, a new event wins over the clear
					`PTM_OFS_STATUS: begin
						next_st.sticky_a = st.sticky_a & ~wbyte[0];
						next_st.sticky_p = st.sticky_p & ~wbyte[1];
					end
					default: begin
					end
				endcase
			end
		end
		if (next_st.flag_a) begin
			next_st.sticky_a = 1'b1;
		end
		if (next_st.flag_p) begin
			next_st.sticky_p = 1'b1;
		end
		// Single pulse: A match ends the pulse, pin edge starts it
		if (mode_field == PTM_MODE_PWM && pin_function_field == 2'h3) begin
			if (counting && match_a) begin
				next_st.ctrl0[`PTM_C0_RUN] = 1'b0;
				next_st.flag_a             = 1'b1;
				next_st.sticky_a           = 1'b1;
			end else if (!run_control_bit && ext_edge) begin
				next_st.ctrl0[`PTM_C0_RUN] = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// State register, frozen while the clock enable is low
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			st <= '{bus: PTM_BUS_IDLE, default: '0};
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	// Outputs straight from flip-flops
	assign wb_dat_o            = st.rdat;
	assign wb_ack_o            = st.ack;
	assign timer_output_pin_o  = st.pin;
	assign compare_a_flag_o    = st.flag_a;
	assign period_match_flag_o = st.flag_p;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_run_rise_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && run_rise |=> st.cnt == 10'h000) else $error("count not cleared on run rise");
	chk_pause_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && pause_bit && !run_rise |=> $stable(st.cnt)) else $error("count moved while paused");
	chk_stop_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && !run_control_bit |=> $stable(st.cnt)) else $error("count moved while off");
	chk_flag_a_pulse: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && compare_a_flag_o && !run_control_bit |=> !compare_a_flag_o) else $error("flag A held");
	chk_no_pflag_cclr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		mode_field == PTM_MODE_CMP && clear_select_bit && $stable(st.ctrl1) |-> !next_st.flag_p)
		else $error("period flag with clear select");
	chk_out_init: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && run_rise |=> st.out_lvl == $past(output_control_bit)) else $error("initial level wrong");
	chk_pulse_end: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && counting && match_a && mode_field == PTM_MODE_PWM && pin_function_field == 2'h3
		|=> !run_control_bit) else $error("pulse did not end");
	chk_clear_wrap: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && counting && clr |=> st.cnt == 10'h000) else $error("counter not cleared");
	chk_ack_once: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	cov_flag_a: cover property (@(posedge clk_sys_i) disable iff (rst_i) compare_a_flag_o);
	cov_flag_p: cover property (@(posedge clk_sys_i) disable iff (rst_i) period_match_flag_o);
	cov_pulse: cover property (@(posedge clk_sys_i) disable iff (rst_i)
		mode_field == PTM_MODE_PWM && pin_function_field == 2'h3 && run_rise);
endmodule : ptm_timer

// *** tb/ptm_far_side.sv ***
// Far side of the timer: external clock pin plus the high and sub clock sources.
// Assumes one system clock; all pins change by non-blocking assignment on its rising edge.
`timescale 1ns/1ps
module ptm_far_side (
	// Clock and reset
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	// Clock sources and pin
	output logic      ext_clock_pin_o,
	output logic      clk_high_tick_o,
	output logic      clk_sub_o
);
	logic [3:0] div;
	initial ext_clock_pin_o = 1'b0;
	// Free-running internal sources: high tick every 4 cycles, sub clock period 16
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			div <= 4'h0;
		end else begin
			div <= div + 4'h1;
		end
	end
	assign clk_high_tick_o = (div[1:0] == 2'h3);
	assign clk_sub_o       = div[3];
	// Pin held high three cycles and low at least three so the edge detector sees every edge
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge clk_sys_i) ext_clock_pin_o <= 1'b1;
			repeat (3) @(posedge clk_sys_i);
			ext_clock_pin_o <= 1'b0;
			repeat (3) @(posedge clk_sys_i);
		end
	endtask : pulse
endmodule : ptm_far_side

// *** tb/ptm_timer_tb.sv ***
// Self-checking bench for the periodic timer: register access, counting, modes, pin.
// Assumes the far-side model for clock sources and the constants header on the path.
`timescale 1ns/1ps
`include "ptm_consts.svh"
module ptm_timer_tb;
	import ptm_pkg::*;
	logic        clk_sys_i = 1'b0;
	logic        rst_i     = 1'b1;
	logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [7:0]  wb_adr = 8'h00;
	logic [3:0]  wb_sel = 4'h0;
	logic [3:0]  sel_q  = 4'hF;
	logic        ce     = 1'b1;
	logic [31:0] wb_dat = 32'h0000_0000;
	logic [31:0] wb_dat_o, rd;
	logic        wb_ack_o, pin, fa, fp, ext, htick, sub;
	int          num_errors = 0, samples_checked = 0, a_cnt = 0, p_cnt = 0, lo_cnt = 0, a0, p0;
	always #12.5 clk_sys_i = ~clk_sys_i;
	ptm_far_side ptm_far_side_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ext_clock_pin_o(ext),
		.clk_high_tick_o(htick), .clk_sub_o(sub));
	ptm_timer ptm_timer_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce),
		.clk_high_tick_i(htick), .clk_sub_i(sub), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clock_pin_i(ext),
		.timer_output_pin_o(pin), .compare_a_flag_o(fa), .period_match_flag_o(fp));
	// Event monitors: a flag held more than one cycle counts more than once
	always @(posedge clk_sys_i) begin
		if (fa === 1'b1) a_cnt++;
		if (fp === 1'b1) p_cnt++;
		if (pin === 1'b0) lo_cnt++;
	end
	task automatic complete_run();
		$display("checked %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : complete_run
	// Classic single cycle; request held until ack is sampled at a rising edge
	task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d);
		bit done;
		done = 0;
		@(posedge clk_sys_i);
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} <= {2'b11, we, a, sel_q, {4{d}}};
		for (int n = 0; n < 20 && !done; n++) begin
			@(posedge clk_sys_i);
			if (wb_ack_o === 1'b1) done = 1;
		end
		if (!done) begin
			num_errors++;
			complete_run();
		end
		rd = wb_dat_o;
		{wb_cyc, wb_stb, wb_we} <= 3'b000;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic check_byte(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 8'h00);
		samples_checked++;
		if (rd !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, exp, rd);
		end
	endtask : check_byte
	task automatic check_bit(input logic got, input logic exp);
		@(posedge clk_sys_i);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : check_bit
	// Stop, configure while off, then restart with a run-bit rise
	task automatic setup(input logic [7:0] c1, input logic [9:0] a, input logic [9:0] p);
		wr(`PTM_OFS_CTRL0, 8'h60);
		wr(`PTM_OFS_CTRL1, c1 & 8'hFD);
		wr(`PTM_OFS_CMPA_LO, a[7:0]);
		wr(`PTM_OFS_CMPA_HI, {6'h00, a[9:8]});
		wr(`PTM_OFS_PER_LO, p[7:0]);
		wr(`PTM_OFS_PER_HI, {6'h00, p[9:8]});
		wr(`PTM_OFS_CTRL0, 8'h68);
		repeat (3) @(posedge clk_sys_i);
		a0 = a_cnt;
		p0 = p_cnt;
	endtask : setup
	initial begin
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		for (int r = 0; r < 9; r++) check_byte(8'(4 * r), 32'h0000_0000);
		check_byte(8'h24, 32'h0000_0000);
		// Every internal source must advance the count; upper counter bits stay zero
		for (int k = 0; k < 6; k++) begin
			wr(`PTM_OFS_CTRL0, {1'b0, 3'(k), 4'h0});
			wr(`PTM_OFS_CTRL0, {1'b0, 3'(k), 4'h8});
			repeat (600) @(posedge clk_sys_i);
			wr(`PTM_OFS_CTRL0, 8'h00);
			xfer(1'b0, `PTM_OFS_CNT_LO, 8'h00);
			a0 = rd;
			xfer(1'b0, `PTM_OFS_CNT_HI, 8'h00);
			check_bit(rd[31:2] == 0 && (a0 != 0 || rd[1:0] != 0), 1'b1);
		end
		// Pin edge counting, pause, stop and restart-clear
		setup(8'h00, 10'h000, 10'h000);
		ptm_far_side_i.pulse(5);
		check_byte(`PTM_OFS_CNT_LO, 32'h0000_0005);
		// Clock enable low freezes everything, pin edges included
		ce <= 1'b0;
		ptm_far_side_i.pulse(2);
		ce <= 1'b1;
		check_byte(`PTM_OFS_CNT_LO, 32'h0000_0005);
		wr(`PTM_OFS_CTRL0, 8'hE8);
		ptm_far_side_i.pulse(3);
		check_byte(`PTM_OFS_CNT_LO, 32'h0000_0005);
		wr(`PTM_OFS_CTRL0, 8'h68);
		ptm_far_side_i.pulse(2);
		wr(`PTM_OFS_CTRL0, 8'h60);
		ptm_far_side_i.pulse(2);
		check_byte(`PTM_OFS_CNT_LO, 32'h0000_0007);
		wr(`PTM_OFS_CTRL0, 8'h78);
		ptm_far_side_i.pulse(2);
		check_byte(`PTM_OFS_CNT_LO, 32'h0000_0002);
		// Staged pair: low byte alone must not show
		wr(`PTM_OFS_CMPA_LO, 8'h34);
		check_byte(`PTM_OFS_CMPA_LO, 32'h0000_0000);
		wr(`PTM_OFS_CMPA_HI, 8'h02);
		check_byte(`PTM_OFS_CMPA_LO, 32'h0000_0034);
		check_byte(`PTM_OFS_CMPA_HI, 32'h0000_0002);
		// A write without the low byte lane selected is ignored
		sel_q = 4'hE;
		wr(`PTM_OFS_PER_LO, 8'h77);
		sel_q = 4'hF;
		check_byte(`PTM_OFS_PER_LO, 32'h0000_0000);
		// Compare mode, toggle on A, clear on period
		setup(8'h30, 10'h002, 10'h004);
		check_bit(pin, 1'b0);
		ptm_far_side_i.pulse(2);
		check_bit(pin, 1'b1);
		check_bit(a_cnt - a0 == 1, 1'b1);
		ptm_far_side_i.pulse(2);
		check_bit(p_cnt - p0 == 1, 1'b1);
		check_byte(`PTM_OFS_STATUS, 32'h0000_0003);
		wr(`PTM_OFS_STATUS, 8'h03);
		check_byte(`PTM_OFS_STATUS, 32'h0000_0000);
		// Requested level equals initial level
		setup(8'h28, 10'h002, 10'h004);
		ptm_far_side_i.pulse(3);
		check_bit(pin, 1'b1);
		// Clear on A only, no period flag
		setup(8'h31, 10'h003, 10'h001);
		ptm_far_side_i.pulse(5);
		check_bit(p_cnt == p0 && a_cnt - a0 == 1, 1'b1);
		xfer(1'b0, `PTM_OFS_CNT_LO, 8'h00);
		check_bit(rd <= 3, 1'b1);
		// Timer mode pin, forced levels, polarity
		setup(8'hCC, 10'h001, 10'h000);
		ptm_far_side_i.pulse(2);
		check_bit(pin, 1'b0);
		setup(8'h98, 10'h001, 10'h002);
		check_bit(pin, 1'b1);
		setup(8'h88, 10'h001, 10'h002);
		check_bit(pin, 1'b0);
		setup(8'h9C, 10'h001, 10'h002);
		check_bit(pin, 1'b0);
		// Duty at or above period gives a steady active level
		setup(8'hA8, 10'h003, 10'h002);
		a0 = lo_cnt;
		ptm_far_side_i.pulse(4);
		check_bit(lo_cnt == a0, 1'b1);
		// Single pulse: A match ends it, pin edge starts it again
		setup(8'hB8, 10'h003, 10'h000);
		check_bit(pin, 1'b1);
		ptm_far_side_i.pulse(3);
		check_byte(`PTM_OFS_CTRL0, 32'h0000_0060);
		check_bit(pin, 1'b0);
		ptm_far_side_i.pulse(1);
		check_byte(`PTM_OFS_CTRL0, 32'h0000_0068);
		complete_run();
	end
endmodule : ptm_timer_tb
